// File: verilog/tpr_repeater.sv
// Purpose: three port regenerating fieldbus repeater, one electrical and two optical ports
// Assumes: all rx inputs idle high and synchronous to clk
// Notes: rates above clock/4 need a faster clock; the first frames are spent on locking
`include "tpr_regs.svh"
module tpr_repeater
    import tpr_pkg::*;
#(
    parameter int CLK_HZ = `TPR_CLK_HZ,
    parameter int SILENCE_CYC = `TPR_SILENCE_CYC,
    parameter int ACT_HOLD_CYC = `TPR_ACT_HOLD_CYC,
    parameter int BLINK_CYC = `TPR_BLINK_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // receive lines
    input wire logic rx_electrical_port,
    input wire logic rx_optical_port_a,
    input wire logic rx_optical_port_b,
    // transmit lines
    output logic tx_electrical_port,
    output logic tx_electrical_port_oe,
    output logic tx_optical_port_a,
    output logic tx_optical_port_b,
    // indicators
    output logic power_rate_indicator,
    output logic act_electrical_port,
    output logic act_optical_port_a,
    output logic act_optical_port_b
);
    tpr_line_if lif();
    tpr_src_t src;
    logic [2:0] rx_q;
    logic src_q;
    logic src_d;
    tpr_period_t phase;
    logic samp;
    logic [`TPR_DELAY_BITS-1:0] dline;
    logic tx_bit;
    logic [4:0] quiet;
    logic [31:0] act_cnt [3];
    logic [31:0] blink_cnt;
    logic blink;

    // registered receive lines, merged line for rate finding
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_q <= 3'h7;
        end else begin
            rx_q <= {rx_optical_port_b, rx_optical_port_a, rx_electrical_port};
        end
    end
    assign lif.line = &rx_q;

    tpr_rate_detect #(.CLK_HZ(CLK_HZ), .SILENCE_CYC(SILENCE_CYC)) u_detect (
        .clk(clk),
        .rst(rst),
        .lif(lif)
    );

    // level of the selected source
    always_comb begin
        unique case (src)
            TPR_SRC_ELEC: src_q = rx_q[0];
            TPR_SRC_OPTA: src_q = rx_q[1];
            TPR_SRC_OPTB: src_q = rx_q[2];
            default: src_q = 1'b1;
        endcase
    end

    // source selection: first port to start, held until it goes quiet
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src <= TPR_SRC_IDLE;
        end else if (!lif.locked) begin
            src <= TPR_SRC_IDLE;
        end else if (src == TPR_SRC_IDLE) begin
            if (!rx_q[0]) src <= TPR_SRC_ELEC;
            else if (!rx_q[1]) src <= TPR_SRC_OPTA;
            else if (!rx_q[2]) src <= TPR_SRC_OPTB;
        end else if (quiet >= 5'(`TPR_IDLE_BITS)) begin
            src <= TPR_SRC_IDLE;
        end
    end

    // bit clock: phase resyncs on each source edge, samples at mid bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_d <= 1'b1;
            phase <= 16'h0000;
        end else begin
            src_d <= src_q;
            if (src_q != src_d || src == TPR_SRC_IDLE) phase <= 16'h0001;
            else if (phase >= lif.period - 16'h0001) phase <= 16'h0000;
            else phase <= phase + 16'h0001;
        end
    end
    assign samp = (src != TPR_SRC_IDLE) && (phase == (lif.period >> 1));

    // delay line of sampled bits; its length sets the through delay
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dline <= '1;
            tx_bit <= 1'b1;
            quiet <= 5'h00;
        end else if (src == TPR_SRC_IDLE) begin
            dline <= '1;
            tx_bit <= 1'b1;
            quiet <= 5'h00;
        end else if (samp) begin
            dline <= {dline[`TPR_DELAY_BITS-2:0], src_q};
            tx_bit <= dline[`TPR_DELAY_BITS-1];
            quiet <= src_q ? ((quiet == 5'h1f) ? quiet : quiet + 5'h01) : 5'h00;
        end
    end

    // forwarding to every port except the receiving one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_electrical_port <= 1'b1;
            tx_electrical_port_oe <= 1'b0;
            tx_optical_port_a <= 1'b1;
            tx_optical_port_b <= 1'b1;
        end else begin
            tx_optical_port_a <= (src == TPR_SRC_ELEC || src == TPR_SRC_OPTB) ? tx_bit : 1'b1;
            tx_optical_port_b <= (src == TPR_SRC_ELEC || src == TPR_SRC_OPTA) ? tx_bit : 1'b1;
            tx_electrical_port <= (src == TPR_SRC_OPTA || src == TPR_SRC_OPTB) ? tx_bit : 1'b1;
            // driver enabled only while forwarding so the station can talk otherwise
            tx_electrical_port_oe <= (src == TPR_SRC_OPTA || src == TPR_SRC_OPTB);
        end
    end

    // activity stretch so single bits stay visible
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 3; i++) act_cnt[i] <= 32'h0000_0000;
            act_electrical_port <= 1'b0;
            act_optical_port_a <= 1'b0;
            act_optical_port_b <= 1'b0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (!rx_q[i]) act_cnt[i] <= 32'(ACT_HOLD_CYC);
                else if (act_cnt[i] != 32'h0000_0000) act_cnt[i] <= act_cnt[i] - 32'h0000_0001;
            end
            act_electrical_port <= !rx_q[0] || act_cnt[0] > 32'h0000_0001;
            act_optical_port_a <= !rx_q[1] || act_cnt[1] > 32'h0000_0001;
            act_optical_port_b <= !rx_q[2] || act_cnt[2] > 32'h0000_0001;
        end
    end

    // power/rate indicator: blink until locked
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            blink_cnt <= 32'h0000_0000;
            blink <= 1'b0;
            power_rate_indicator <= 1'b0;
        end else begin
            if (blink_cnt >= 32'(BLINK_CYC) - 32'h0000_0001) begin
                blink_cnt <= 32'h0000_0000;
                blink <= !blink;
            end else begin
                blink_cnt <= blink_cnt + 32'h0000_0001;
            end
            power_rate_indicator <= lif.locked ? 1'b1 : blink;
        end
    end

    property p_idle_quiet;
        @(posedge clk) disable iff (rst)
        src == TPR_SRC_IDLE |=> tx_optical_port_a && tx_optical_port_b && tx_electrical_port && !tx_electrical_port_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("transmit while idle");

    property p_elec_both;
        @(posedge clk) disable iff (rst)
        src == TPR_SRC_ELEC |=> tx_optical_port_a == tx_optical_port_b && tx_optical_port_a == $past(tx_bit);
    endproperty
    a_elec_both: assert property (p_elec_both) else $error("optical ports differ");

    property p_opta_fwd;
        @(posedge clk) disable iff (rst)
        src == TPR_SRC_OPTA |=> tx_electrical_port_oe && tx_electrical_port == tx_optical_port_b;
    endproperty
    a_opta_fwd: assert property (p_opta_fwd) else $error("port a traffic not forwarded");

    property p_no_echo;
        @(posedge clk) disable iff (rst)
        (src == TPR_SRC_OPTA |=> tx_optical_port_a) and (src == TPR_SRC_OPTB |=> tx_optical_port_b)
        and (src == TPR_SRC_ELEC |=> !tx_electrical_port_oe);
    endproperty
    a_no_echo: assert property (p_no_echo) else $error("echo to receiving port");

    property p_retimed;
        @(posedge clk) disable iff (rst)
        !samp && src != TPR_SRC_IDLE && $past(src) != TPR_SRC_IDLE |=> tx_bit == $past(tx_bit);
    endproperty
    a_retimed: assert property (p_retimed) else $error("output moved off the bit clock");

    property p_delay_line;
        @(posedge clk) disable iff (rst)
        samp && src != TPR_SRC_IDLE ##1 src != TPR_SRC_IDLE |-> dline[0] == $past(src_q) && tx_bit == $past(dline[5]);
    endproperty
    a_delay_line: assert property (p_delay_line) else $error("delay line misaligned");

    property p_lit_locked;
        @(posedge clk) disable iff (rst)
        lif.locked ##1 lif.locked |-> power_rate_indicator;
    endproperty
    a_lit_locked: assert property (p_lit_locked) else $error("indicator not steady when locked");

    property p_act_on;
        @(posedge clk) disable iff (rst)
        !rx_q[1] |=> act_optical_port_a;
    endproperty
    a_act_on: assert property (p_act_on) else $error("activity light dark while receiving");

    property p_act_off;
        @(posedge clk) disable iff (rst)
        rx_q[0] && act_cnt[0] == 32'h0000_0000 |=> !act_electrical_port;
    endproperty
    a_act_off: assert property (p_act_off) else $error("activity light on without traffic");

    property p_unlocked_idle;
        @(posedge clk) disable iff (rst)
        !lif.locked |=> src == TPR_SRC_IDLE;
    endproperty
    a_unlocked_idle: assert property (p_unlocked_idle) else $error("forwarding without a rate");

    c_elec: cover property (@(posedge clk) disable iff (rst) src == TPR_SRC_ELEC ##1 samp);
    c_opta: cover property (@(posedge clk) disable iff (rst) src == TPR_SRC_OPTA ##1 !tx_electrical_port);
    c_optb: cover property (@(posedge clk) disable iff (rst) src == TPR_SRC_OPTB ##1 src == TPR_SRC_IDLE);
endmodule // tpr_repeater

// File: pkg/tpr_regs.svh
// Purpose: numeric constants of the three port fieldbus repeater
// Assumes: 10 MHz system clock
// Notes: rates are listed fastest first
`ifndef TPR_REGS_SVH
`define TPR_REGS_SVH
`define TPR_CLK_HZ 10000000
`define TPR_CLK_PERIOD_NS 100
`define TPR_NUM_RATES 10
`define TPR_RATE0_BPS 12000000
`define TPR_RATE1_BPS 6000000
`define TPR_RATE2_BPS 3000000
`define TPR_RATE3_BPS 1500000
`define TPR_RATE4_BPS 500000
`define TPR_RATE5_BPS 187500
`define TPR_RATE6_BPS 93750
`define TPR_RATE7_BPS 45450
`define TPR_RATE8_BPS 19200
`define TPR_RATE9_BPS 9600
`define TPR_MIN_PERIOD_CYC 4
`define TPR_DELAY_BITS 6
`define TPR_IDLE_BITS 12
`define TPR_LOCK_PULSES 4
`define TPR_SILENCE_MS 1000
`define TPR_ACT_HOLD_MS 10
`define TPR_BLINK_MS 250
`define TPR_SILENCE_CYC (`TPR_SILENCE_MS * (`TPR_CLK_HZ / 1000))
`define TPR_ACT_HOLD_CYC (`TPR_ACT_HOLD_MS * (`TPR_CLK_HZ / 1000))
`define TPR_BLINK_CYC (`TPR_BLINK_MS * (`TPR_CLK_HZ / 1000))
`endif

// File: pkg/tpr_pkg.sv
// Purpose: types and rate arithmetic of the repeater
// Assumes: tpr_regs.svh supplies every figure
// Notes: periods are whole clock cycles, rounded down
`include "tpr_regs.svh"
package tpr_pkg;
    typedef logic [15:0] tpr_period_t;
    typedef logic [3:0] tpr_rate_idx_t;
    typedef enum logic [3:0] {
        TPR_SRC_IDLE = 4'b0001,
        TPR_SRC_ELEC = 4'b0010,
        TPR_SRC_OPTA = 4'b0100,
        TPR_SRC_OPTB = 4'b1000
    } tpr_src_t;

    // bit period in clock cycles of table entry idx
    function automatic tpr_period_t tpr_period(input int clk_hz, input tpr_rate_idx_t idx);
        int bps;
        bps = `TPR_RATE9_BPS;
        unique case (idx)
            4'h0: bps = `TPR_RATE0_BPS;
            4'h1: bps = `TPR_RATE1_BPS;
            4'h2: bps = `TPR_RATE2_BPS;
            4'h3: bps = `TPR_RATE3_BPS;
            4'h4: bps = `TPR_RATE4_BPS;
            4'h5: bps = `TPR_RATE5_BPS;
            4'h6: bps = `TPR_RATE6_BPS;
            4'h7: bps = `TPR_RATE7_BPS;
            4'h8: bps = `TPR_RATE8_BPS;
            default: bps = `TPR_RATE9_BPS;
        endcase
        return tpr_period_t'(clk_hz / bps);
    endfunction
endpackage

// File: pkg/tpr_line_if.sv
// Purpose: carries the merged bus line and the locked rate between modules
// Assumes: one clock domain
// Notes: line is low while any port receives a low bit
interface tpr_line_if;
    logic line;
    logic locked;
    tpr_pkg::tpr_period_t period;
    modport detect (input line, output locked, output period);
    modport user (output line, input locked, input period);
endinterface

// File: verilog/tpr_rate_detect.sv
// Purpose: finds the bus bit rate from low pulse widths and locks to it
// Assumes: line is a registered, clock synchronous level
// Notes: rates faster than clock/4 cannot be resolved and are never matched
`include "tpr_regs.svh"
module tpr_rate_detect
    import tpr_pkg::*;
#(
    parameter int CLK_HZ = `TPR_CLK_HZ,
    parameter int SILENCE_CYC = `TPR_SILENCE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // merged line and result
    tpr_line_if.detect lif
);
    localparam logic [3:0] LOCK_PULSES = 4'(`TPR_LOCK_PULSES);
    logic line_d;
    tpr_period_t width;
    tpr_rate_idx_t cand;
    logic [3:0] match_cnt;
    tpr_rate_idx_t rate_idx;
    logic [31:0] silence;
    logic hit;
    tpr_rate_idx_t hit_idx;

    // fastest table entry whose period fits the measured low width
    always_comb begin
        hit = 1'b0;
        hit_idx = 4'h0;
        for (int i = `TPR_NUM_RATES - 1; i >= 0; i--) begin
            if (tpr_period(CLK_HZ, 4'(i)) >= tpr_period_t'(`TPR_MIN_PERIOD_CYC) &&
                {2'b00, width} * 18'd4 >= {2'b00, tpr_period(CLK_HZ, 4'(i))} * 18'd3 &&
                {2'b00, width} * 18'd2 <= {2'b00, tpr_period(CLK_HZ, 4'(i))} * 18'd3) begin
                hit = 1'b1;
                hit_idx = 4'(i);
            end
        end
    end

    // low pulse width counter, saturating
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_d <= 1'b1;
            width <= 16'h0000;
        end else begin
            line_d <= lif.line;
            if (lif.line) width <= 16'h0000;
            else if (width != 16'hffff) width <= width + 16'h0001;
        end
    end

    // lock after several agreeing pulses; a faster match relocks, long silence unlocks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cand <= 4'h9;
            match_cnt <= 4'h0;
            rate_idx <= 4'h9;
            lif.locked <= 1'b0;
            silence <= 32'h0000_0000;
        end else begin
            silence <= lif.line ? silence + 32'h0000_0001 : 32'h0000_0000;
            if (lif.locked && silence >= 32'(SILENCE_CYC)) begin
                lif.locked <= 1'b0;
                match_cnt <= 4'h0;
            end else if (lif.line && !line_d && hit && (!lif.locked || hit_idx < rate_idx)) begin
                if (hit_idx != cand) begin
                    cand <= hit_idx;
                    match_cnt <= 4'h1;
                end else if (match_cnt + 4'h1 >= LOCK_PULSES) begin
                    rate_idx <= cand;
                    lif.locked <= 1'b1;
                    match_cnt <= 4'h0;
                end else begin
                    match_cnt <= match_cnt + 4'h1;
                end
            end
        end
    end

    assign lif.period = tpr_period(CLK_HZ, rate_idx);

    property p_lock_needs_edge;
        @(posedge clk) disable iff (rst)
        $rose(lif.locked) |-> $past(lif.line) && !$past(line_d) && $past(hit);
    endproperty
    a_lock_needs_edge: assert property (p_lock_needs_edge) else $error("lock without a matching pulse");

    property p_period_usable;
        @(posedge clk) disable iff (rst)
        lif.locked |-> lif.period >= tpr_period_t'(`TPR_MIN_PERIOD_CYC);
    endproperty
    a_period_usable: assert property (p_period_usable) else $error("locked to an unusable rate");

    c_lock: cover property (@(posedge clk) disable iff (rst) $rose(lif.locked));
endmodule // tpr_rate_detect

// File: tb/tpr_station_model.sv
// Purpose: fieldbus station or neighbouring repeater driving one receive line
// Assumes: every bit lasts a whole number of clock cycles
// Notes: the line rests high between frames, as a terminated idle bus does
module tpr_station_model (
    // clock
    input wire logic clk,
    // line into the repeater
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle level from time zero so the repeater never sees a false start bit
    initial rxd = 1'b1;

    // plain nrz bits, lsb first; no link monitoring traffic is ever sent
    task automatic send(input int period, input logic [15:0] bits, input int n);
        for (int k = 0; k < n; k++) begin
            @(negedge clk);
            rxd = bits[k];
            repeat (period - 1) @(negedge clk);
        end
        @(negedge clk);
        rxd = 1'b1;
    endtask
endmodule // tpr_station_model

// File: tb/tpr_repeater_tb.sv
// Purpose: self-checking bench of the three port repeater
// Assumes: 10 MHz clock, shortened silence, hold and blink counts
// Notes: 12, 6 and 3 Mbps cannot lock at this clock and are left out
`include "tpr_regs.svh"
module tpr_repeater_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // must outlast six bit times at 9.6 Kbps so a low bit in flight is not dropped
    localparam int SIL = 6500;
    localparam int HOLD = 50;
    localparam int BLINK = 20;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rx_e, rx_a, rx_b;
    logic tx_e, tx_oe, tx_a, tx_b, pwr, act_e, act_a, act_b;
    logic [3:0] lines;
    int n_errors = 0;
    int num_checks = 0;
    integer seed = 75800;
    int rate_bps [10] = '{`TPR_RATE0_BPS, `TPR_RATE1_BPS, `TPR_RATE2_BPS, `TPR_RATE3_BPS, `TPR_RATE4_BPS,
        `TPR_RATE5_BPS, `TPR_RATE6_BPS, `TPR_RATE7_BPS, `TPR_RATE8_BPS, `TPR_RATE9_BPS};

    // 100 ns period
    always #50 clk = ~clk;

    assign lines = {tx_oe, tx_e, tx_a, tx_b};

    tpr_repeater #(
        .CLK_HZ(`TPR_CLK_HZ),
        .SILENCE_CYC(SIL),
        .ACT_HOLD_CYC(HOLD),
        .BLINK_CYC(BLINK)
    ) tpr_repeater_i (
        .clk(clk),
        .rst(rst),
        .rx_electrical_port(rx_e),
        .rx_optical_port_a(rx_a),
        .rx_optical_port_b(rx_b),
        .tx_electrical_port(tx_e),
        .tx_electrical_port_oe(tx_oe),
        .tx_optical_port_a(tx_a),
        .tx_optical_port_b(tx_b),
        .power_rate_indicator(pwr),
        .act_electrical_port(act_e),
        .act_optical_port_a(act_a),
        .act_optical_port_b(act_b)
    );

    // one far-side party per port
    tpr_station_model st_e_i (.clk(clk), .rxd(rx_e));
    tpr_station_model st_a_i (.clk(clk), .rxd(rx_a));
    tpr_station_model st_b_i (.clk(clk), .rxd(rx_b));

    task automatic chk_lines(input logic [3:0] got, input logic [3:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %b want %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %b want %b", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // expected {oe, elec, opt a, opt b}; the receiving port stays idle high
    function automatic logic [3:0] exp_lines(input int src, input logic b);
        case (src)
            0: return {1'b0, 1'b1, b, b};
            1: return {1'b1, b, 1'b1, b};
            default: return {1'b1, b, b, 1'b1};
        endcase
    endfunction

    task automatic send_on(input int src, input int p, input logic [15:0] bits, input int n);
        case (src)
            0: st_e_i.send(p, bits, n);
            1: st_a_i.send(p, bits, n);
            default: st_b_i.send(p, bits, n);
        endcase
    endtask

    // unlocked indicator must show both levels within three blink halves
    task automatic chk_blink();
        logic seen0, seen1;
        seen0 = 1'b0;
        seen1 = 1'b0;
        repeat (3 * BLINK) begin
            @(negedge clk);
            if (pwr === 1'b0) seen0 = 1'b1;
            if (pwr === 1'b1) seen1 = 1'b1;
        end
        chk_flag(seen0, 1'b1, "power dark phase");
        chk_flag(seen1, 1'b1, "power lit phase");
    endtask

    // lock on a preamble, forward one random frame, then fall silent to unlock
    task automatic run_rate(input int idx, input int src);
        int p, cnt;
        logic [15:0] data;
        p = `TPR_CLK_HZ / rate_bps[idx];
        // bits 0, 5 and 9 low: high runs stay far below the silence timeout
        data = 16'($random(seed)) & 16'h01de;
        fork
            send_on(src, p, 16'h00aa, 8);
            for (int i = 1; i <= 8 * p; i++) begin
                @(negedge clk);
                chk_lines(lines, 4'b0111, "traffic before lock");
                if (i == p / 2) chk_lines({1'b0, act_e, act_a, act_b}, {1'b0, 3'(3'b100 >> src)}, "activity");
            end
        join
        // short gap: a long one would count toward the silence timeout at slow rates
        repeat (4) @(negedge clk);
        fork
            send_on(src, p, data, 10);
        join_none
        // watch the data line itself; oe may rise well before the first bit
        cnt = 0;
        while ((src == 0 ? tx_a : tx_e) === 1'b1 && cnt <= 7 * p + 8) begin
            @(negedge clk);
            cnt++;
        end
        chk_flag(cnt >= 6 * p && cnt <= 7 * p + 8, 1'b1, "through delay");
        repeat (p / 2) @(negedge clk);
        for (int k = 0; k < 10; k++) begin
            chk_lines(lines, exp_lines(src, data[k]), "forwarded bit");
            chk_flag(pwr, 1'b1, "power steady when locked");
            repeat (p) @(negedge clk);
        end
        // let the source release and the activity hold run out
        repeat (8 * p + HOLD) @(negedge clk);
        chk_lines(lines, 4'b0111, "idle after frame");
        chk_lines({1'b0, act_e, act_a, act_b}, 4'b0000, "activity dark");
        // silence drops the lock so the next rate starts afresh
        // silence has counted since the last low bit, about fourteen bits ago
        if (SIL + 10 > 14 * p + HOLD) repeat (SIL + 10 - 14 * p - HOLD) @(negedge clk);
        chk_blink();
    endtask

    // main sequence, inputs changed on the falling edge
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        chk_lines(lines, 4'b0111, "idle after reset");
        chk_blink();
        for (int idx = 3; idx < `TPR_NUM_RATES; idx++) begin
            run_rate(idx, idx % 3);
        end
        tally_and_finish();
    end

    // about 93k cycles expected; cut off a hang well beyond that
    initial begin
        #12000000;
        n_errors++;
        tally_and_finish();
    end
endmodule // tpr_repeater_tb
